// ### pkg/lbhs_pkg.sv
package lbhs_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam int unsigned LINE_WORDS = 320;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned BIT_W = 4;
  localparam int unsigned DIV_W = 4;

  // ------------------------------------------------------------------
  // Command opcodes in the upper four bits of a command word
  // ------------------------------------------------------------------
  localparam int unsigned OP_MSB = 15;
  localparam int unsigned OP_LSB = 12;
  localparam logic [3:0] OP_INIT = 4'h8;
  localparam logic [3:0] OP_DMA_REQUEST_N_WORDS = 4'h7;
  localparam logic [3:0] OP_FORMAT = 4'h4;
  localparam logic [3:0] OP_MODE = 4'h2;
  localparam logic [3:0] OP_STOP = 4'h1;

  // ------------------------------------------------------------------
  // Field positions inside the command words
  // ------------------------------------------------------------------
  localparam int unsigned INIT_CLKSEL_BIT = 0;
  localparam int unsigned INIT_DIV_LSB = 1;
  localparam int unsigned INIT_DIV_MSB = 3;
  localparam int unsigned INIT_DMA_BIT = 4;
  localparam int unsigned INIT_TOGGLE_BIT = 5;
  localparam int unsigned FMT_LSB_BIT = 0;
  localparam int unsigned FMT_LIFO_BIT = 1;
  localparam int unsigned MODE_SEND_BIT = 0;
  localparam int unsigned DMA_REQUEST_N_CNT_MSB = 8;

  // ------------------------------------------------------------------
  // Reset values of the command settings and the highest divider code
  // ------------------------------------------------------------------
  localparam logic RST_CLKSEL_SYS = 1'b0;
  localparam logic [2:0] RST_DIV_CODE = 3'h0;
  localparam logic RST_LSB_FIRST = 1'b0;
  localparam logic RST_LIFO = 1'b0;
  localparam logic [2:0] DIV_CODE_MAX = 3'h4;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_STATIC = 3'b001,
    MODE_WRITE = 3'b010,
    MODE_SEND = 3'b100
  } lbhs_mode_t;

  typedef struct packed {
    logic writeStrobeN;
    logic chipSelectN;
    logic dmaGrantN;
    logic cmdDataSel;
  } lbhs_host_pins_t;

  typedef struct packed {
    lbhs_host_pins_t pinSync1;
    lbhs_host_pins_t pinSync2;
    logic [WORD_W-1:0] busSync1;
    logic [WORD_W-1:0] busSync2;
    logic prevStrobeN;
    lbhs_mode_t mode;
    logic clkSelSys;
    logic [2:0] divCode;
    logic dmaStore;
    logic toggleEn;
    logic lsbFirst;
    logic lifo;
    logic dreqSet;
    logic [ADDR_W-1:0] dreqWords;
    logic [ADDR_W-1:0] dmaCount;
    logic [ADDR_W-1:0] lineLen;
    logic [ADDR_W-1:0] rdCount;
    logic [BIT_W-1:0] bitIdx;
    logic [WORD_W-1:0] shiftWord;
    logic [DIV_W-1:0] divCnt;
    logic prevSwapN;
    logic dmaRequestN;
    logic irqN;
    logic sendActiveN;
    logic serialClkOut;
    logic serialDataOut;
  } lbhs_state_t;

endpackage : lbhs_pkg

// ### logic/lbhs_top.sv
// Functional notes
// - Bus word is taken as command or data at the write strobe rising edge.
// - Host data path is one sixteen-bit parallel word driven during writes.
// - Processor writes count only with chip select low; otherwise ignored.
// - DMA grant low makes the write a line-memory data word, chip select aside.
// - Processor write with select high goes to commands, low goes to memory.
// - Reset clears settings; active-low outputs high, clock high, serial data low.
// - DMA request goes low on entering write mode when DMA storage and count set.
// - DMA request returns high after one more DMA write than the programmed count.
// - Interrupt goes low once the stored line is fully shifted out.
// - Interrupt releases on a processor access, or on the swap pulse when toggle is enabled with the peripheral clock.
// - Send-active output is low throughout send mode, high when the line completes.
// - Peripheral clock counts only while its gate input is low.
// - With the continuous clock selected the gate input is ignored.
// - Initialization command selects peripheral clock or continuous clock.
// - Continuous clock offers five divided output clock rates.
// - Divide ratios are two, four, eight, sixteen and thirty-two.
// - Send mode shifts out the stored line as a serial bit stream.
// - After reset: peripheral clock, most significant bit first, first-in first-out.
`timescale 1ns/10ps

module lbhs_top #(
  parameter int unsigned LINE_DEPTH = lbhs_pkg::LINE_WORDS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [lbhs_pkg::WORD_W-1:0] hostBusWord,
  input wire lbhs_pkg::lbhs_host_pins_t hostPins,
  input wire logic swapPulseN,
  input wire logic inputClockGateN,
  input wire logic clkIn,
  output logic dmaRequestN,
  output logic irqN,
  output logic sendActiveN,
  output logic serialClkOut,
  output logic serialDataOut
);
  import lbhs_pkg::*;

  lbhs_state_t state_reg;
  lbhs_state_t state_next;
  logic [WORD_W-1:0] lineMem [LINE_DEPTH];

  logic strobeRise;
  logic dmaWr;
  logic cpuWr;
  logic cmdWr;
  logic dataWr;
  logic memWe;
  logic enterWrite;
  logic enterSend;
  logic lineDone;
  logic divTick;
  logic shiftTick;
  logic [3:0] opcode;
  logic [ADDR_W-1:0] rdAddr;
  logic [DIV_W-1:0] divLast;

  // ------------------------------------------------------------------
  // Access decode on the synchronised strobe edge
  // ------------------------------------------------------------------
  // The bus word travels through the same two stages as the strobe so that it stays aligned with the edge.
  assign strobeRise = state_reg.pinSync2.writeStrobeN & ~state_reg.prevStrobeN;
  assign dmaWr = strobeRise & ~state_reg.pinSync2.dmaGrantN;
  assign cpuWr = strobeRise & state_reg.pinSync2.dmaGrantN & ~state_reg.pinSync2.chipSelectN;
  assign cmdWr = cpuWr & state_reg.pinSync2.cmdDataSel;
  assign dataWr = dmaWr | (cpuWr & ~state_reg.pinSync2.cmdDataSel);
  assign opcode = state_reg.busSync2[OP_MSB:OP_LSB];
  assign memWe = dataWr && (state_reg.mode == MODE_WRITE) && (state_reg.lineLen < ADDR_W'(LINE_DEPTH));

  // Divider for the continuous clock; one tick per half period of the outgoing clock.
  assign divLast = DIV_W'((5'h01 << state_reg.divCode) - 5'h01);
  assign divTick = (state_reg.divCnt == divLast);
  assign rdAddr = state_reg.lifo ? ADDR_W'(state_reg.lineLen - state_reg.rdCount - 9'h001) : state_reg.rdCount;

  // ------------------------------------------------------------------
  // Bit selection for the serial stream
  // ------------------------------------------------------------------
  function automatic logic pickBit(input logic [WORD_W-1:0] w, input logic [BIT_W-1:0] i, input logic lsb);
    pickBit = lsb ? w[i] : w[BIT_W'(WORD_W - 1) - i];
  endfunction : pickBit

  // ------------------------------------------------------------------
  // Line memory write port; it needs no reset as reads follow writes.
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (memWe) begin
      lineMem[state_reg.lineLen] <= state_reg.busSync2;
    end
  end

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    enterWrite = 1'b0;
    enterSend = 1'b0;
    lineDone = 1'b0;
    shiftTick = 1'b0;
    state_next.pinSync1 = hostPins;
    state_next.pinSync2 = state_reg.pinSync1;
    state_next.busSync1 = hostBusWord;
    state_next.busSync2 = state_reg.busSync1;
    state_next.prevStrobeN = state_reg.pinSync2.writeStrobeN;
    state_next.prevSwapN = swapPulseN;
    // Any processor access releases the interrupt; a completing line below still wins.
    if (cpuWr) begin
      state_next.irqN = 1'b1;
    end
    // Command handling; while sending only stop is taken, the host is not expected to try more.
    if (cmdWr) begin
      unique case (state_reg.mode)
        MODE_STATIC: begin
          if (opcode == OP_INIT) begin
            state_next.clkSelSys = state_reg.busSync2[INIT_CLKSEL_BIT];
            state_next.divCode = (state_reg.busSync2[INIT_DIV_MSB:INIT_DIV_LSB] > DIV_CODE_MAX) ? DIV_CODE_MAX
                                 : state_reg.busSync2[INIT_DIV_MSB:INIT_DIV_LSB];
            state_next.dmaStore = state_reg.busSync2[INIT_DMA_BIT];
            state_next.toggleEn = state_reg.busSync2[INIT_TOGGLE_BIT];
          end else if (opcode == OP_FORMAT) begin
            state_next.lsbFirst = state_reg.busSync2[FMT_LSB_BIT];
            state_next.lifo = state_reg.busSync2[FMT_LIFO_BIT];
          end else if (opcode == OP_DMA_REQUEST_N_WORDS) begin
            state_next.dreqWords = state_reg.busSync2[DMA_REQUEST_N_CNT_MSB:0];
            state_next.dreqSet = 1'b1;
          end else if (opcode == OP_MODE) begin
            enterWrite = ~state_reg.busSync2[MODE_SEND_BIT];
          end
        end
        MODE_WRITE: begin
          if (opcode == OP_MODE) begin
            enterSend = state_reg.busSync2[MODE_SEND_BIT];
          end
        end
        MODE_SEND: begin
        end
      endcase
      if (opcode == OP_STOP) begin
        state_next.mode = MODE_STATIC;
        state_next.dmaRequestN = 1'b1;
        state_next.sendActiveN = 1'b1;
        state_next.serialClkOut = 1'b1;
        state_next.serialDataOut = 1'b0;
      end
    end
    // The swap pulse reverses write and send modes when the toggle arrangement is in use with the peripheral clock selected.
    if (state_reg.prevSwapN && !swapPulseN && state_reg.toggleEn && !state_reg.clkSelSys) begin
      state_next.irqN = 1'b1;
      enterSend = (state_reg.mode == MODE_WRITE);
      enterWrite = (state_reg.mode == MODE_SEND);
    end
    // Counting DMA words; the request rises on the write made after the programmed count is reached.
    if (dmaWr && (state_reg.mode == MODE_WRITE) && !state_reg.dmaRequestN) begin
      if (state_reg.dmaCount == state_reg.dreqWords) begin
        state_next.dmaRequestN = 1'b1;
      end
      state_next.dmaCount = ADDR_W'(state_reg.dmaCount + 9'h001);
    end
    if (memWe) begin
      state_next.lineLen = ADDR_W'(state_reg.lineLen + 9'h001);
    end
    // Clock source; the divider free-runs so its ticks are evenly spaced.
    state_next.divCnt = divTick ? '0 : DIV_W'(state_reg.divCnt + 4'h1);
    if (state_reg.mode == MODE_SEND) begin
      if (state_reg.clkSelSys) begin
        if (divTick) begin
          state_next.serialClkOut = ~state_reg.serialClkOut;
          shiftTick = state_reg.serialClkOut;
        end
      end else if (!inputClockGateN) begin
        state_next.serialClkOut = clkIn;
        shiftTick = state_reg.serialClkOut & ~clkIn;
      end
    end
    // Data moves on the falling edge so the peripheral sees it settled at the rising edge.
    if (shiftTick) begin
      if (state_reg.bitIdx == BIT_W'(WORD_W - 1)) begin
        if (state_reg.rdCount == ADDR_W'(state_reg.lineLen - 9'h001)) begin
          lineDone = 1'b1;
        end else begin
          state_next.rdCount = ADDR_W'(state_reg.rdCount + 9'h001);
          state_next.bitIdx = '0;
          state_next.shiftWord = lineMem[state_reg.lifo ? ADDR_W'(rdAddr - 9'h001) : ADDR_W'(rdAddr + 9'h001)];
          state_next.serialDataOut = pickBit(state_next.shiftWord, '0, state_reg.lsbFirst);
        end
      end else begin
        state_next.bitIdx = BIT_W'(state_reg.bitIdx + 4'h1);
        state_next.serialDataOut = pickBit(state_reg.shiftWord, state_next.bitIdx, state_reg.lsbFirst);
      end
    end
    if (enterWrite) begin
      state_next.mode = MODE_WRITE;
      state_next.lineLen = '0;
      state_next.dmaCount = '0;
      state_next.dmaRequestN = ~(state_reg.dmaStore & state_reg.dreqSet);
      // A swap out of send mode ends the frame, so the link falls back to its idle levels.
      state_next.sendActiveN = 1'b1;
      state_next.serialClkOut = 1'b1;
      state_next.serialDataOut = 1'b0;
    end
    if (enterSend) begin
      state_next.mode = MODE_SEND;
      state_next.dmaRequestN = 1'b1;
      state_next.sendActiveN = 1'b0;
      // The clock starts low so its first rise samples bit zero; a high start would let the first fall skip it.
      state_next.serialClkOut = 1'b0;
      state_next.rdCount = '0;
      state_next.bitIdx = '0;
      state_next.shiftWord = lineMem[state_reg.lifo ? ADDR_W'(state_reg.lineLen - 9'h001) : '0];
      state_next.serialDataOut = pickBit(state_next.shiftWord, '0, state_reg.lsbFirst);
      lineDone = (state_reg.lineLen == '0);
    end
    // Completion sets the interrupt after any clear in the same cycle.
    if (lineDone) begin
      state_next.mode = MODE_STATIC;
      state_next.sendActiveN = 1'b1;
      state_next.irqN = 1'b0;
      state_next.serialClkOut = 1'b1;
      state_next.serialDataOut = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.pinSync1 <= '1;
      state_reg.pinSync2 <= '1;
      state_reg.prevStrobeN <= 1'b1;
      state_reg.prevSwapN <= 1'b1;
      state_reg.mode <= MODE_STATIC;
      state_reg.clkSelSys <= RST_CLKSEL_SYS;
      state_reg.divCode <= RST_DIV_CODE;
      state_reg.lsbFirst <= RST_LSB_FIRST;
      state_reg.lifo <= RST_LIFO;
      state_reg.dmaRequestN <= 1'b1;
      state_reg.irqN <= 1'b1;
      state_reg.sendActiveN <= 1'b1;
      state_reg.serialClkOut <= 1'b1;
      state_reg.serialDataOut <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign dmaRequestN = state_reg.dmaRequestN;
  assign irqN = state_reg.irqN;
  assign sendActiveN = state_reg.sendActiveN;
  assign serialClkOut = state_reg.serialClkOut;
  assign serialDataOut = state_reg.serialDataOut;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence dmaArmed;
    enterWrite && state_reg.dmaStore && state_reg.dreqSet;
  endsequence
  sequence lastDmaWord;
    dmaWr && !state_reg.dmaRequestN && (state_reg.dmaCount == state_reg.dreqWords) && (state_reg.mode == MODE_WRITE);
  endsequence

  dma_request_n_entry_a: assert property (dmaArmed |=> !dmaRequestN) else $error("DMA request not low at write entry");
  dma_request_n_release_a: assert property (lastDmaWord |=> dmaRequestN) else $error("DMA request not released");
  irq_set_a: assert property (lineDone |=> !irqN && sendActiveN) else $error("Line end flags wrong");
  irq_clear_a: assert property (cpuWr && !lineDone && !irqN |=> irqN) else $error("Interrupt not released");
  busy_send_a: assert property ((state_reg.mode == MODE_SEND) |-> !sendActiveN) else $error("Busy high in send");
  cs_ignore_a: assert property (strobeRise && hostPinsIgnored() && !lineDone && !enterWrite && !enterSend
    |=> $stable(state_reg.mode) && $stable(irqN)) else $error("Deselected write had an effect");
  gate_block_a: assert property ((state_reg.mode == MODE_SEND) && !state_reg.clkSelSys && inputClockGateN
    |=> $stable(serialClkOut) || sendActiveN) else $error("Gated clock moved output");
  sys_rate_a: assert property ((state_reg.mode == MODE_SEND) && ($past(state_reg.mode) == MODE_SEND)
    && state_reg.clkSelSys && (state_next.mode == MODE_SEND) && !$past(divTick) |-> $stable(serialClkOut))
    else $error("Clock moved off divider tick");

  function automatic logic hostPinsIgnored();
    hostPinsIgnored = state_reg.pinSync2.chipSelectN & state_reg.pinSync2.dmaGrantN;
  endfunction : hostPinsIgnored

endmodule : lbhs_top

// ### dv/lbhs_peer.sv
`timescale 1ns/10ps

// ------------------------------------------------------------------
// Serial peripheral on the far side of the line buffer
// ------------------------------------------------------------------
module lbhs_peer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic gateHold,
  input wire logic [3:0] halfCycles,
  input wire logic sendActiveN,
  input wire logic serialClkOut,
  input wire logic serialDataOut,
  output logic clkIn,
  output logic inputClockGateN
);
  logic prevClk;
  logic [3:0] halfCnt;
  int sinceRise;
  int risePeriod = 0;
  logic rxBits[$];

  // A peripheral that cannot take more bits pauses by raising its gate.
  assign inputClockGateN = gateHold;

  // The request clock runs only inside a frame and rests high between frames.
  always @(negedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkIn <= 1'b1;
      halfCnt <= 4'h1;
    end else if (sendActiveN) begin
      clkIn <= 1'b1;
      halfCnt <= 4'h1;
    end else if (halfCnt >= halfCycles) begin
      clkIn <= ~clkIn;
      halfCnt <= 4'h1;
    end else begin
      halfCnt <= halfCnt + 4'h1;
    end
  end

  // Bits are taken at each rising clock inside the frame; the spacing of rises is kept too.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prevClk <= 1'b1;
      sinceRise <= 0;
    end else begin
      prevClk <= serialClkOut;
      sinceRise <= sinceRise + 1;
      if (serialClkOut && !prevClk && !sendActiveN) begin
        rxBits.push_back(serialDataOut);
        risePeriod <= sinceRise;
        sinceRise <= 1;
      end
    end
  end
endmodule : lbhs_peer

// ### dv/lbhs_top_tb.sv
`timescale 1ns/10ps

module lbhs_top_tb;
  import lbhs_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [WORD_W-1:0] hostBusWord = '0;
  lbhs_host_pins_t hostPins = '1;
  logic swapPulseN = 1'b1;
  logic gateHold = 1'b0;
  logic [3:0] halfCycles = 4'h3;
  logic clkIn, inputClockGateN, dmaRequestN, irqN, sendActiveN, serialClkOut, serialDataOut;
  logic cfgSys = 1'b0;
  logic cfgLsb = 1'b0;
  logic cfgLifo = 1'b0;
  logic [2:0] cfgCode = 3'h0;
  logic [WORD_W-1:0] words[$];
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;

  lbhs_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .hostBusWord(hostBusWord), .hostPins(hostPins),
    .swapPulseN(swapPulseN), .inputClockGateN(inputClockGateN), .clkIn(clkIn),
    .dmaRequestN(dmaRequestN), .irqN(irqN), .sendActiveN(sendActiveN),
    .serialClkOut(serialClkOut), .serialDataOut(serialDataOut));

  lbhs_peer peer (.ref_clk(ref_clk), .rst_n(rst_n), .gateHold(gateHold), .halfCycles(halfCycles),
    .sendActiveN(sendActiveN), .serialClkOut(serialClkOut), .serialDataOut(serialDataOut),
    .clkIn(clkIn), .inputClockGateN(inputClockGateN));

  // Free-running system clock at 100 MHz.
  always #5 ref_clk = ~ref_clk;

  // ------------------------------------------------------------------
  // Checking and reporting
  // ------------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  // A hung handshake would stall the run, so a cycle ceiling cuts it short.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      $display("timeout at %0t", $time);
      close_out();
    end
  end

  // Expected serial bit i from the stored words and the chosen word and bit order.
  function automatic logic exp_bit(input int i);
    logic [WORD_W-1:0] w;
    int n;
    n = i / WORD_W;
    w = cfgLifo ? words[words.size() - 1 - n] : words[n];
    return cfgLsb ? w[i % WORD_W] : w[WORD_W - 1 - (i % WORD_W)];
  endfunction : exp_bit

  // ------------------------------------------------------------------
  // Host bus cycles
  // ------------------------------------------------------------------
  // Qualifiers and word stay put until four edges after the strobe rises; the bus is then inverted.
  task automatic wr(input logic cs, input logic grant, input logic cd, input logic [WORD_W-1:0] w);
    @(negedge ref_clk);
    hostBusWord = w;
    hostPins = '{1'b0, cs, grant, cd};
    repeat (3) @(negedge ref_clk);
    hostPins.writeStrobeN = 1'b1;
    repeat (4) @(negedge ref_clk);
    hostPins = '1;
    hostBusWord = ~w;
  endtask : wr

  // The swap pulse stays low for two cycles; only its falling edge acts, so one pulse is one event.
  task automatic swap_pulse();
    @(negedge ref_clk);
    swapPulseN = 1'b0;
    repeat (2) @(negedge ref_clk);
    swapPulseN = 1'b1;
    @(negedge ref_clk);
  endtask : swap_pulse

  task automatic cfg(input logic sys, input logic [2:0] code, input logic dma, input logic lsb, input logic lifo);
    wr(1'b0, 1'b1, 1'b1, {OP_INIT, 7'h00, dma, code, sys});
    wr(1'b0, 1'b1, 1'b1, {OP_FORMAT, 10'h000, lifo, lsb});
    cfgSys = sys;
    cfgCode = code;
    cfgLsb = lsb;
    cfgLifo = lifo;
  endtask : cfg

  // Enter write mode and store n words, each followed by a deselected write that must vanish.
  task automatic load(input int n);
    int k;
    words.delete();
    wr(1'b0, 1'b1, 1'b1, {OP_MODE, 12'h000});
    chk_bit(irqN, 1'b1);
    for (k = 0; k < n; k++) begin
      words.push_back(WORD_W'($urandom));
      wr(1'b0, 1'b1, 1'b0, words[k]);
      wr(1'b1, 1'b1, 1'b0, ~words[k]);
    end
  endtask : load

  // Start the line by command (how 0, or 1 with a mid-line pause) or by swap pulse (how 2), then compare the stream.
  task automatic finish(input string nm, input int how);
    int k;
    int held;
    peer.rxBits.delete();
    if (how == 2) begin
      swap_pulse();
      chk_bit(sendActiveN, 1'b0);
    end else begin
      wr(1'b1, 1'b1, 1'b1, {OP_MODE, 12'h001});
      chk_bit(sendActiveN, 1'b1);
      wr(1'b0, 1'b1, 1'b1, {OP_MODE, 12'h001});
      chk_bit(sendActiveN, 1'b0);
    end
    if (how == 1) begin
      repeat (30) @(negedge ref_clk);
      gateHold = 1'b1;
      repeat (4) @(negedge ref_clk);
      held = peer.rxBits.size();
      repeat (60) @(negedge ref_clk);
      chk_val(peer.rxBits.size(), held);
      gateHold = 1'b0;
    end
    k = 0;
    while (sendActiveN === 1'b0 && k < 20000) begin
      @(negedge ref_clk);
      k++;
    end
    chk_bit(sendActiveN, 1'b1);
    chk_bit(irqN, 1'b0);
    chk_val(peer.rxBits.size(), words.size() * WORD_W);
    for (k = 0; k < peer.rxBits.size(); k++) begin
      chk_bit(peer.rxBits[k], exp_bit(k));
    end
    if (cfgSys) begin
      chk_val(peer.risePeriod, 32'h2 << cfgCode);
    end
    // A deselected access must leave the pending interrupt alone.
    wr(1'b1, 1'b1, 1'b1, {OP_MODE, 12'h000});
    chk_bit(irqN, 1'b0);
    if (how == 2) begin
      swap_pulse();
      chk_bit(irqN, 1'b1);
    end
    $display("test %0s done", nm);
  endtask : finish

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    int i;
    void'($urandom(57));
    repeat (3) @(negedge ref_clk);
    chk_val({dmaRequestN, irqN, sendActiveN, serialClkOut, serialDataOut}, 32'h1e);
    rst_n = 1'b1;
    $display("test reset done");
    load(3);
    finish("defaults", 1'b1);
    for (i = 0; i < 5; i++) begin
      cfg(1'b1, 3'(i), 1'b0, i[0], i[1]);
      gateHold = 1'b1;
      load(2);
      finish("divider", 1'b0);
      gateHold = 1'b0;
    end
    for (i = 0; i < 3; i++) begin
      halfCycles = 4'(2 + $urandom_range(6));
      cfg(1'b0, 3'h0, 1'b0, 1'($urandom), 1'($urandom));
      load(1 + $urandom_range(4));
      finish("random", 1'b0);
    end
    cfg(1'b0, 3'h0, 1'b1, 1'b0, 1'b0);
    wr(1'b0, 1'b1, 1'b1, {OP_DMA_REQUEST_N_WORDS, 3'h0, 9'h002});
    load(0);
    chk_bit(dmaRequestN, 1'b0);
    for (i = 0; i < 3; i++) begin
      chk_bit(dmaRequestN, 1'b0);
      words.push_back(WORD_W'($urandom));
      wr(1'b1, 1'b0, i[0], words[i]);
    end
    chk_bit(dmaRequestN, 1'b1);
    finish("dma", 1'b0);
    // Toggle arrangement on the request clock; a stop or a second swap ends a line early without an interrupt.
    wr(1'b0, 1'b1, 1'b1, {OP_INIT, 12'h020});
    load(2);
    finish("swap", 2);
    load(1);
    swap_pulse();
    wr(1'b0, 1'b1, 1'b1, {OP_STOP, 12'h000});
    chk_bit(sendActiveN, 1'b1);
    chk_bit(irqN, 1'b1);
    load(1);
    swap_pulse();
    swap_pulse();
    chk_bit(sendActiveN, 1'b1);
    chk_bit(serialClkOut, 1'b1);
    $display("test stop done");
    close_out();
  end
endmodule : lbhs_top_tb
